// File: tb/sscb_host_model.sv
// Host-side model that makes item requests on the bank's item port.
// Assumes a bank that answers each request with item_ack one cycle after taking it.
`timescale 1ns/1ps
`include "sscb_consts.svh"

module sscb_host_model (
  input  wire logic                 sys_clk,    // System clock.
  output logic                      item_req,   // Request strobe.
  output logic                      item_wr,    // Write select.
  output sscb_pkg::sscb_item_t      item_sel,   // Item code.
  output sscb_pkg::sscb_word_t      item_wdata, // Write data.
  input  wire sscb_pkg::sscb_word_t item_rdata, // Read data.
  input  wire logic                 item_ack    // Answer strobe.
);
  import sscb_pkg::*;
  initial begin
    item_req = 1'b0;
    item_wr = 1'b0;
    item_sel = 3'h7;
    item_wdata = 16'h0000;
  end

  // A missing answer yields unknown data, so the caller's comparison fails.
  task automatic access(input logic wr, input sscb_item_t sel, input sscb_word_t wd,
                        output sscb_word_t rd);
    int n;
    @(posedge sys_clk);
    item_req <= 1'b1;
    item_wr <= wr;
    item_sel <= sel;
    item_wdata <= wd;
    @(posedge sys_clk);
    item_req <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (item_ack !== 1'b1 && n < 4);
    rd = (item_ack === 1'b1) ? item_rdata : 16'hxxxx;
    // Stale qualifiers are scrambled so nothing can lean on them.
    item_wdata <= ~wd;
    item_sel <= ~sel;
  endtask

  task automatic write_alarm(input logic [5:0] cfg, input logic [5:0] mask);
    sscb_word_t v;
    access(1'b1, `SSCB_ITEM_ALARM, {2'h0, mask, 2'h0, cfg}, v);
  endtask

  task automatic write_reset(input logic [2:0] en);
    sscb_word_t v;
    access(1'b1, `SSCB_ITEM_RESET_CFG, {10'h000, 2'h3, en[2], en[1], 1'b1, en[0]}, v);
  endtask

  // Two reads on consecutive edges, the way a polling host may issue them.
  task automatic read_pair(input sscb_item_t sel, output sscb_word_t rd0,
                           output sscb_word_t rd1);
    @(posedge sys_clk);
    item_req <= 1'b1;
    item_wr <= 1'b0;
    item_sel <= sel;
    @(posedge sys_clk);
    @(posedge sys_clk);
    rd0 = (item_ack === 1'b1) ? item_rdata : 16'hxxxx;
    item_req <= 1'b0;
    @(posedge sys_clk);
    rd1 = (item_ack === 1'b1) ? item_rdata : 16'hxxxx;
  endtask
endmodule

// File: tb/system_status_control_bank_test.sv
// Self-checking bench for the system status and control bank.
// Assumes the bank and its synchroniser are compiled alongside the host model.
`timescale 1ns/1ps
`include "sscb_consts.svh"

module system_status_control_bank_test;
  import sscb_pkg::*;
  logic       sys_clk;
  logic       sys_rst;
  logic [6:0] fin;
  logic [4:0] fout;
  logic       trip;
  logic       cpu_f;
  logic       fr;
  logic       mains;
  logic       prim;
  logic [2:0] apres;
  logic [2:0] agood;
  logic       req;
  logic       wr;
  sscb_item_t sel;
  sscb_word_t wd;
  sscb_word_t rdat;
  logic       ack;
  logic       alarm;
  logic       bp_rst;
  logic       c_rst;
  sscb_word_t v;
  sscb_word_t v2;
  int         n_fail = 0;
  int         n_checks = 0;
  int         cycles = 0;

  sscb_host_model i_host (.sys_clk(sys_clk), .item_req(req), .item_wr(wr), .item_sel(sel),
    .item_wdata(wd), .item_rdata(rdat), .item_ack(ack));

  sscb_bank i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .item_req(req), .item_wr(wr),
    .item_sel(sel), .item_wdata(wd), .item_rdata(rdat), .item_ack(ack),
    .voltage_set_select(fin[0]), .current_set_select(fin[1]), .kill_in(fin[2]),
    .interlock_in(fin[3]), .remote_enable_in(fin[4]), .local_enable_in(fin[5]),
    .nim_select(fin[6]), .over_current(fout[0]), .under_voltage(fout[1]),
    .over_voltage(fout[2]), .channel_on_flag(fout[3]), .fan_failure(fout[4]),
    .trip_in(trip), .cpu_failure(cpu_f), .front_reset_in(fr), .mains_good(mains),
    .primary_good(prim), .addon_present(apres), .addon_good(agood),
    .general_alarm_output(alarm), .backplane_reset(bp_rst), .cpu_reset(c_rst));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic finish_test;
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      finish_test;
    end
  end

  task automatic check(input string name, input sscb_word_t exp, input sscb_word_t got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic rd_chk(input sscb_item_t s, input sscb_word_t exp, input string name);
    sscb_word_t r;
    i_host.access(1'b0, s, 16'h0000, r);
    check(name, exp, r);
  endtask

  // Two synchroniser stages and one output register lie between a pin and its effect.
  task automatic settle;
    repeat (4) @(posedge sys_clk);
  endtask

  function automatic logic [1:0] hc(input logic p, input logic g);
    return !p ? `SSCB_HEALTH_ABSENT : (g ? `SSCB_HEALTH_GOOD : `SSCB_HEALTH_FAIL);
  endfunction

  initial begin
    sys_rst = 1'b1;
    fin = 7'h00;
    fout = 5'h00;
    trip = 1'b0;
    cpu_f = 1'b0;
    fr = 1'b0;
    mains = 1'b1;
    prim = 1'b1;
    apres = 3'h0;
    agood = 3'h0;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd_chk(`SSCB_ITEM_ALARM, 16'h0000, "alarm cfg at reset");
    rd_chk(`SSCB_ITEM_RESET_CFG, `SSCB_RST_RESET, "reset cfg at reset");
    rd_chk(3'h5, 16'h0000, "unmapped item");
    i_host.write_alarm(6'h3f, 6'h3f);
    rd_chk(`SSCB_ITEM_ALARM, 16'h003f, "alarm cfg all set");
    i_host.write_alarm(6'h00, 6'h0a);
    rd_chk(`SSCB_ITEM_ALARM, 16'h0035, "alarm cfg masked");
    i_host.access(1'b1, `SSCB_ITEM_ALARM, 16'hc0ff, v);
    rd_chk(`SSCB_ITEM_ALARM, 16'h0035, "alarm cfg no mask");
    i_host.access(1'b1, `SSCB_ITEM_FRONT_IN, 16'hffff, v);
    rd_chk(`SSCB_ITEM_FRONT_IN, 16'h0000, "front inputs after write");
    // Each cause in turn, against each monitored condition; k of 1 forces on.
    for (int k = 1; k < 6; k++) begin
      i_host.write_alarm(6'h01 | (6'h01 << k), 6'h3f);
      for (int p = 0; p < 4; p++) begin
        @(posedge sys_clk);
        fout[2] <= (p == 0);
        fout[0] <= (p == 1);
        fout[1] <= (p == 2);
        trip <= (p == 3);
        settle;
        check("alarm output", {15'h0, (k == 1) || (k == p + 2)}, {15'h0, alarm});
      end
    end
    i_host.write_alarm(6'h02, 6'h3f);
    settle;
    check("alarm output disabled", 16'h0000, {15'h0, alarm});
    for (int i = 0; i < 7; i++) begin
      @(posedge sys_clk);
      fin <= 7'h01 << i;
      fout <= 5'h00;
      trip <= 1'b0;
      settle;
      rd_chk(`SSCB_ITEM_FRONT_IN, 16'h0001 << i, "front inputs");
      rd_chk(`SSCB_ITEM_FRONT_IN, 16'h0001 << i, "front inputs again");
    end
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      fin <= 7'h00;
      fout <= 5'h01 << i;
      settle;
      rd_chk(`SSCB_ITEM_FRONT_OUT, (i == 5) ? 16'h0000 : 16'h0001 << ((i == 4) ? 8 : i),
             "front outputs");
    end
    @(posedge sys_clk);
    fout <= 5'h11;
    settle;
    i_host.read_pair(`SSCB_ITEM_FRONT_OUT, v, v2);
    check("front outputs first", 16'h0101, v);
    check("front outputs second", 16'h0101, v2);
    for (int c = 0; c < 32; c++) begin
      if (c[1:0] == 2'h0) begin
        i_host.write_reset(c[4:2]);
        rd_chk(`SSCB_ITEM_RESET_CFG, 16'h0032 | {12'h0, c[4], c[3], 1'b0, c[2]},
               "reset cfg");
      end
      @(posedge sys_clk);
      cpu_f <= c[0];
      fr <= c[1];
      settle;
      check("backplane reset", {15'h0, c[2] & c[0] | c[3] & c[1]}, {15'h0, bp_rst});
      check("cpu reset", {15'h0, c[4] & c[1]}, {15'h0, c_rst});
    end
    i_host.access(1'b1, `SSCB_ITEM_RESET_CFG, 16'hffff, v);
    rd_chk(`SSCB_ITEM_RESET_CFG, 16'h003f, "reset cfg fixed bits");
    for (int s = 0; s < 32; s++) begin
      @(posedge sys_clk);
      mains <= s[0];
      prim <= s[1];
      apres <= s[4:2];
      agood <= s[4:2] ^ {s[0], s[1], s[0]};
      settle;
      rd_chk(`SSCB_ITEM_SUPPLY, {6'h00, hc(apres[2], agood[2]), hc(apres[1], agood[1]),
             hc(apres[0], agood[0]), hc(1'b1, prim), hc(1'b1, mains)},
             "supply status");
    end
    finish_test;
  end
endmodule

// File: verilog/sscb_bank.sv
// System status and control bank: alarm-output and reset-source configuration,
// front-panel status words and supply-module health report behind an item port.
// Assumes one item request at most per cycle and asynchronous status pins.
`timescale 1ns/1ps
`include "sscb_consts.svh"

// Notes on behaviour
// RL1: The alarm configuration is 16 bits, bit 0 enables the alarm output and bit 1 forces it on.
// RL2: With the output enabled, over-voltage, over-current, under-voltage or trip drive it when their bit is set.
// RL3: A write changes configuration bits 0 to 5 only where mask bits 8 to 13 are written as one.
// RL4: Bits 6, 7, 14 and 15 of the alarm configuration are unused, written as zero and read as zero.
// RL5: The front input word reports voltage set, current set, kill, interlock, remote and local enable in bits 0 to 5.
// RL6: Front input bit 6 reports the logic standard, zero for TTL and one for NIM.
// RL7: Front input bits 7 to 15 read as zero.
// RL8: The front output word reports over-current, under-voltage, over-voltage, channel-on and fan failure in bits 0 to 3 and 8.
// RL9: Reset configuration bit 0 lets a processor failure cause a backplane reset.
// RL10: Reset configuration bit 2 lets the front-panel reset input cause a backplane reset.
// RL11: Reset configuration bit 3 lets the front-panel reset input cause a processor reset.
// RL12: Writers put ones in reset configuration bits 1, 4 and 5.
// RL13: Writers put zeros in reset configuration bits 6 to 15.
// RL14: The supply report lists mains, primary and three add-ons, with -1 failed and 1 good for the first two.
// RL15: Each add-on field reads -1 when failed, 0 when absent and 1 when good.
// RL16: Front status words show the current sampled pins on every read with no latching or side effect.
module sscb_bank (
  input  wire logic                sys_clk,          // System clock, 50 MHz.
  input  wire logic                sys_rst,          // Asynchronous reset, active high.
  input  wire logic                item_req,         // Item access request, one cycle.
  input  wire logic                item_wr,          // High for a write with item_req.
  input  wire sscb_pkg::sscb_item_t item_sel,        // Item code.
  input  wire sscb_pkg::sscb_word_t item_wdata,      // Write data.
  output sscb_pkg::sscb_word_t     item_rdata,       // Read data, valid with item_ack.
  output logic                     item_ack,         // Access answered, one cycle.
  input  wire logic                voltage_set_select, // Voltage set switch pin.
  input  wire logic                current_set_select, // Current set switch pin.
  input  wire logic                kill_in,          // Kill input pin.
  input  wire logic                interlock_in,     // Interlock input pin.
  input  wire logic                remote_enable_in, // Remote enable pin.
  input  wire logic                local_enable_in,  // Local enable pin.
  input  wire logic                nim_select,       // Logic standard, 1 for NIM.
  input  wire logic                over_current,     // Over-current condition.
  input  wire logic                under_voltage,    // Under-voltage condition.
  input  wire logic                over_voltage,     // Over-voltage condition.
  input  wire logic                channel_on_flag,  // Some channel is on.
  input  wire logic                fan_failure,      // Fan failure condition.
  input  wire logic                trip_in,          // Trip condition.
  input  wire logic                cpu_failure,      // Processor failure indication.
  input  wire logic                front_reset_in,   // Front-panel reset input.
  input  wire logic                mains_good,       // Mains present and good.
  input  wire logic                primary_good,     // Primary supply module good.
  input  wire logic [2:0]          addon_present,    // Add-on module present, per slot.
  input  wire logic [2:0]          addon_good,       // Add-on module good, per slot.
  output logic                     general_alarm_output, // Alarm output.
  output logic                     backplane_reset,  // Backplane reset request.
  output logic                     cpu_reset         // Processor reset request.
);
  import sscb_pkg::*;

  sscb_pin_if pin_bus ();

  assign pin_bus.raw = {addon_good, addon_present, primary_good, mains_good,
                        front_reset_in, cpu_failure, trip_in, fan_failure,
                        channel_on_flag, over_voltage, under_voltage, over_current,
                        nim_select, local_enable_in, remote_enable_in, interlock_in,
                        kill_in, current_set_select, voltage_set_select};

  sscb_sync u_sync (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .pins    (pin_bus.sync_side)
  );

  logic [`SSCB_SYNC_W-1:0]    s;
  logic [`SSCB_ALM_CFG_W-1:0] alarm_cfg_reg;
  logic [`SSCB_ALM_CFG_W-1:0] alarm_cfg_next;
  logic [`SSCB_ALM_CFG_W-1:0] wr_mask;
  sscb_word_t                 reset_cfg_reg;
  sscb_word_t                 front_in_word;
  sscb_word_t                 front_out_word;
  sscb_word_t                 supply_word;
  sscb_word_t                 alarm_word;
  sscb_word_t                 read_mux;
  logic                       alarm_next;
  logic                       wr_alarm;
  logic                       wr_reset;
  sscb_health_t               addon_health [`SSCB_ADDON_N];

  assign s = pin_bus.sync;
  assign wr_alarm = item_req && item_wr && (item_sel == `SSCB_ITEM_ALARM);
  assign wr_reset = item_req && item_wr && (item_sel == `SSCB_ITEM_RESET_CFG);

  // Alarm configuration with per-bit write masks.
  assign wr_mask = item_wdata[`SSCB_ALM_MASK_LSB +: `SSCB_ALM_CFG_W];
  assign alarm_cfg_next = (alarm_cfg_reg & ~wr_mask) |
                          (item_wdata[`SSCB_ALM_CFG_W-1:0] & wr_mask); // RL3

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_cfg_reg <= `SSCB_ALM_RESET;
    end else if (wr_alarm) begin
      alarm_cfg_reg <= alarm_cfg_next; // RL3
    end
  end

  // Unused bits and the write-only mask bits read back as zero.
  assign alarm_word = {10'h000, alarm_cfg_reg}; // RL4

  // Alarm output decision.
  always_comb begin
    alarm_next = alarm_cfg_reg[`SSCB_ALM_ON] |
                 (alarm_cfg_reg[`SSCB_ALM_OV]   & s[`SSCB_S_OVV]) |
                 (alarm_cfg_reg[`SSCB_ALM_OC]   & s[`SSCB_S_OVC]) |
                 (alarm_cfg_reg[`SSCB_ALM_UV]   & s[`SSCB_S_UNV]) |
                 (alarm_cfg_reg[`SSCB_ALM_TRIP] & s[`SSCB_S_TRIP]); // RL2
    alarm_next = alarm_next & alarm_cfg_reg[`SSCB_ALM_EN]; // RL1
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      general_alarm_output <= 1'b0;
    end else begin
      general_alarm_output <= alarm_next; // RL1
    end
  end

  // Reset-source configuration. The whole word is stored; only the selectable bits take write data and the fixed
  // bits are forced so that a careless writer cannot disturb the readback.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reset_cfg_reg <= `SSCB_RST_RESET;
    end else if (wr_reset) begin
      reset_cfg_reg <= (item_wdata & `SSCB_RST_WR_MASK) | `SSCB_RST_FIXED_ONES; // RL12 RL13
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      backplane_reset <= 1'b0;
      cpu_reset       <= 1'b0;
    end else begin
      backplane_reset <= (reset_cfg_reg[`SSCB_RST_CPU_FAIL] & s[`SSCB_S_CPU_FAIL]) | // RL9
                         (reset_cfg_reg[`SSCB_RST_FP_BP] & s[`SSCB_S_FP_RESET]);     // RL10
      cpu_reset       <= reset_cfg_reg[`SSCB_RST_FP_CPU] & s[`SSCB_S_FP_RESET];      // RL11
    end
  end

  // Front-panel status words are built live from the synchronised pins.
  assign front_in_word = {9'h000, s[`SSCB_S_NIM], // RL6 RL7
                          s[`SSCB_S_LOCAL], s[`SSCB_S_REMOTE], s[`SSCB_S_ILOCK],
                          s[`SSCB_S_KILL], s[`SSCB_S_CURRENT_SET_SELECT], s[`SSCB_S_VOLTAGE_SET_SELECT]}; // RL5

  always_comb begin
    front_out_word = 16'h0000;
    front_out_word[`SSCB_FO_OVC]     = s[`SSCB_S_OVC]; // RL8
    front_out_word[`SSCB_FO_UNV]     = s[`SSCB_S_UNV];
    front_out_word[`SSCB_FO_OVV]     = s[`SSCB_S_OVV];
    front_out_word[`SSCB_FO_CHAN_ON] = s[`SSCB_S_CHAN_ON];
    front_out_word[`SSCB_FO_FAN]     = s[`SSCB_S_FAN];
  end

  // Supply-module report, two-bit signed fields from the low end.
  genvar a;
  generate
    for (a = 0; a < `SSCB_ADDON_N; a = a + 1) begin : g_addon
      assign addon_health[a] = !s[`SSCB_S_ADD_PRES + a] ? `SSCB_HEALTH_ABSENT :
                               s[`SSCB_S_ADD_GOOD + a] ? `SSCB_HEALTH_GOOD :
                               `SSCB_HEALTH_FAIL; // RL15
    end
  endgenerate

  assign supply_word = {6'h00, addon_health[2], addon_health[1], addon_health[0],
                        s[`SSCB_S_PRIMARY] ? `SSCB_HEALTH_GOOD : `SSCB_HEALTH_FAIL,
                        s[`SSCB_S_MAINS] ? `SSCB_HEALTH_GOOD : `SSCB_HEALTH_FAIL}; // RL14

  // Read path. Reads have no side effect; a write answers with the old value.
  always_comb begin
    case (item_sel)
      `SSCB_ITEM_ALARM:     read_mux = alarm_word;
      `SSCB_ITEM_FRONT_IN:  read_mux = front_in_word; // RL16
      `SSCB_ITEM_FRONT_OUT: read_mux = front_out_word; // RL16
      `SSCB_ITEM_RESET_CFG: read_mux = reset_cfg_reg;
      `SSCB_ITEM_SUPPLY:    read_mux = supply_word;
      default:              read_mux = 16'h0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      item_ack   <= 1'b0;
      item_rdata <= 16'h0000;
    end else begin
      item_ack <= item_req;
      if (item_req) begin
        item_rdata <= read_mux;
      end
    end
  end

  // Checks on the bank's own behaviour.
  chk_alarm_disable: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL1
    !alarm_cfg_reg[`SSCB_ALM_EN] |=> !general_alarm_output)
    else $error("alarm output active while disabled");

  chk_alarm_forced: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL1
    (alarm_cfg_reg[`SSCB_ALM_EN] && alarm_cfg_reg[`SSCB_ALM_ON]) [*2] |-> general_alarm_output)
    else $error("forced alarm output not on");

  chk_alarm_cause: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL2
    alarm_cfg_reg[`SSCB_ALM_EN] |=>
      general_alarm_output == ($past(alarm_cfg_reg[`SSCB_ALM_ON]) |
        ($past(alarm_cfg_reg[`SSCB_ALM_OV]) & $past(s[`SSCB_S_OVV])) |
        ($past(alarm_cfg_reg[`SSCB_ALM_OC]) & $past(s[`SSCB_S_OVC])) |
        ($past(alarm_cfg_reg[`SSCB_ALM_UV]) & $past(s[`SSCB_S_UNV])) |
        ($past(alarm_cfg_reg[`SSCB_ALM_TRIP]) & $past(s[`SSCB_S_TRIP]))))
    else $error("alarm output does not follow enabled causes");

  chk_mask_write: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL3
    wr_alarm |=>
      ((alarm_cfg_reg & ~$past(wr_mask)) == ($past(alarm_cfg_reg) & ~$past(wr_mask))) &&
      ((alarm_cfg_reg & $past(wr_mask)) == ($past(item_wdata[5:0]) & $past(wr_mask))))
    else $error("alarm configuration ignores write masks");

  chk_alarm_unused: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL4
    (item_req && item_sel == `SSCB_ITEM_ALARM) |=> item_rdata[15:6] == 10'h000)
    else $error("unused alarm configuration bits read nonzero");

  chk_front_in: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL5
    (item_req && item_sel == `SSCB_ITEM_FRONT_IN) |=>
      item_ack && item_rdata[5:0] == $past(s[5:0]))
    else $error("front input word mismatch");

  chk_front_nim: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL6
    (item_req && item_sel == `SSCB_ITEM_FRONT_IN) |=> item_rdata[6] == $past(s[`SSCB_S_NIM]))
    else $error("logic standard bit mismatch");

  chk_front_in_zero: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL7
    (item_req && item_sel == `SSCB_ITEM_FRONT_IN) |=> item_rdata[15:7] == 9'h000)
    else $error("front input upper bits nonzero");

  chk_front_out: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL8
    (item_req && item_sel == `SSCB_ITEM_FRONT_OUT) |=>
      item_rdata == {7'h00, $past(s[`SSCB_S_FAN]), 4'h0, $past(s[`SSCB_S_CHAN_ON]),
                     $past(s[`SSCB_S_OVV]), $past(s[`SSCB_S_UNV]), $past(s[`SSCB_S_OVC])})
    else $error("front output word mismatch");

  chk_bp_reset: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL9
    1'b1 |=> backplane_reset ==
      (($past(reset_cfg_reg[0]) & $past(s[`SSCB_S_CPU_FAIL])) |
       ($past(reset_cfg_reg[2]) & $past(s[`SSCB_S_FP_RESET]))))
    else $error("backplane reset routing wrong");

  chk_fp_bp_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL10
    (!reset_cfg_reg[`SSCB_RST_FP_BP] && !reset_cfg_reg[`SSCB_RST_CPU_FAIL]) |=> !backplane_reset)
    else $error("backplane reset without a selected source");

  chk_cpu_reset: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL11
    (reset_cfg_reg[`SSCB_RST_FP_CPU] && s[`SSCB_S_FP_RESET]) |=> cpu_reset)
    else $error("processor reset not raised");

  chk_reset_fixed: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL12
    (reset_cfg_reg & 16'hfff2) == `SSCB_RST_FIXED_ONES)
    else $error("reset configuration fixed bits disturbed");

  chk_supply_main: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL14
    (item_req && item_sel == `SSCB_ITEM_SUPPLY && !s[`SSCB_S_MAINS]) |=> item_rdata[1:0] == 2'h3)
    else $error("failed mains not reported as minus one");

  chk_supply_addon: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL15
    (item_req && item_sel == `SSCB_ITEM_SUPPLY && !s[`SSCB_S_ADD_PRES]) |=>
      item_rdata[5:4] == 2'h0)
    else $error("absent add-on not reported as zero");

  chk_read_live: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL16
    (item_req && !item_wr && item_sel == `SSCB_ITEM_FRONT_OUT) ##1
    (item_req && !item_wr && item_sel == `SSCB_ITEM_FRONT_OUT) |=>
      item_rdata == $past(front_out_word))
    else $error("front output read not live");

  chk_reset_store: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL9
    wr_reset |=> reset_cfg_reg[`SSCB_RST_CPU_FAIL] == $past(item_wdata[`SSCB_RST_CPU_FAIL]) &&
      reset_cfg_reg[`SSCB_RST_FP_BP] == $past(item_wdata[`SSCB_RST_FP_BP]) &&
      reset_cfg_reg[`SSCB_RST_FP_CPU] == $past(item_wdata[`SSCB_RST_FP_CPU]))
    else $error("reset configuration write not stored");

  chk_fp_bp_route: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL10
    (reset_cfg_reg[`SSCB_RST_FP_BP] && s[`SSCB_S_FP_RESET]) |=> backplane_reset)
    else $error("front reset does not reach the backplane");

  chk_cpu_reset_off: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL11
    !reset_cfg_reg[`SSCB_RST_FP_CPU] |=> !cpu_reset)
    else $error("processor reset without its source selected");

  chk_supply_primary: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL14
    (item_req && item_sel == `SSCB_ITEM_SUPPLY) |=>
      item_rdata[3:2] == ($past(s[`SSCB_S_PRIMARY]) ? 2'h1 : 2'h3))
    else $error("primary module field wrong");

  chk_addon_fail: assert property (@(posedge sys_clk) disable iff (sys_rst) // RL15
    (item_req && item_sel == `SSCB_ITEM_SUPPLY && s[`SSCB_S_ADD_PRES] && !s[`SSCB_S_ADD_GOOD]) |=>
      item_rdata[5:4] == 2'h3)
    else $error("failed add-on not reported as minus one");

  cov_alarm_fires: cover property (@(posedge sys_clk) disable iff (sys_rst)
    !general_alarm_output ##1 general_alarm_output);
  cov_masked_write: cover property (@(posedge sys_clk) disable iff (sys_rst)
    wr_alarm && wr_mask != 6'h00 && wr_mask != 6'h3f);
  cov_cpu_reset: cover property (@(posedge sys_clk) disable iff (sys_rst) cpu_reset);
  cov_back_to_back: cover property (@(posedge sys_clk) disable iff (sys_rst)
    item_req [*2]);
  cov_addon_failed: cover property (@(posedge sys_clk) disable iff (sys_rst)
    item_req && item_sel == `SSCB_ITEM_SUPPLY && addon_health[0] == `SSCB_HEALTH_FAIL);
endmodule

// File: verilog/sscb_consts.svh
// Constants of the system status and control bank: item codes, field positions,
// reset values and synchroniser bit positions.
// Assumes it is included by its bare name wherever these constants are needed.
`ifndef SSCB_CONSTS_SVH
`define SSCB_CONSTS_SVH

// Item codes presented on item_sel.
`define SSCB_ITEM_ALARM       3'h0
`define SSCB_ITEM_FRONT_IN    3'h1
`define SSCB_ITEM_FRONT_OUT   3'h2
`define SSCB_ITEM_RESET_CFG   3'h3
`define SSCB_ITEM_SUPPLY      3'h4

// Alarm-output configuration word.
`define SSCB_ALM_EN           0
`define SSCB_ALM_ON           1
`define SSCB_ALM_OV           2
`define SSCB_ALM_OC           3
`define SSCB_ALM_UV           4
`define SSCB_ALM_TRIP         5
`define SSCB_ALM_CFG_W        6
`define SSCB_ALM_MASK_LSB     8
`define SSCB_ALM_RESET        6'h00

// Reset-source configuration word.
`define SSCB_RST_CPU_FAIL     0
`define SSCB_RST_FP_BP        2
`define SSCB_RST_FP_CPU       3
`define SSCB_RST_WR_MASK      16'h000d
`define SSCB_RST_FIXED_ONES   16'h0032
`define SSCB_RST_RESET        16'h0032

// Front-panel output word positions.
`define SSCB_FO_OVC           0
`define SSCB_FO_UNV           1
`define SSCB_FO_OVV           2
`define SSCB_FO_CHAN_ON       3
`define SSCB_FO_FAN           8

// Supply-module health codes, two bits each, two's complement.
`define SSCB_HEALTH_FAIL      2'h3
`define SSCB_HEALTH_ABSENT    2'h0
`define SSCB_HEALTH_GOOD      2'h1
`define SSCB_ADDON_N          3

// Bit positions inside the synchronised pin vector.
`define SSCB_S_VOLTAGE_SET_SELECT           0
`define SSCB_S_CURRENT_SET_SELECT           1
`define SSCB_S_KILL           2
`define SSCB_S_ILOCK          3
`define SSCB_S_REMOTE         4
`define SSCB_S_LOCAL          5
`define SSCB_S_NIM            6
`define SSCB_S_OVC            7
`define SSCB_S_UNV            8
`define SSCB_S_OVV            9
`define SSCB_S_CHAN_ON        10
`define SSCB_S_FAN            11
`define SSCB_S_TRIP           12
`define SSCB_S_CPU_FAIL       13
`define SSCB_S_FP_RESET       14
`define SSCB_S_MAINS          15
`define SSCB_S_PRIMARY        16
`define SSCB_S_ADD_PRES       17
`define SSCB_S_ADD_GOOD       20
`define SSCB_SYNC_W           23

`endif

// File: verilog/sscb_pin_if.sv
// Carrier between the bank and its pin synchroniser: raw pins out, clean copies back.
// Assumes the bank drives raw and the synchroniser drives sync.
`timescale 1ns/1ps
`include "sscb_consts.svh"

interface sscb_pin_if;
  logic [`SSCB_SYNC_W-1:0] raw;
  logic [`SSCB_SYNC_W-1:0] sync;

  modport sync_side (input raw, output sync);
  modport bank_side (output raw, input sync);
endinterface

// File: verilog/sscb_pkg.sv
// Types shared by the system status and control bank.
// Assumes nothing beyond a SystemVerilog compiler.
package sscb_pkg;
  typedef logic [15:0] sscb_word_t;
  typedef logic [2:0]  sscb_item_t;
  typedef logic [1:0]  sscb_health_t;
endpackage

// File: verilog/sscb_sync.sv
// Two-stage synchroniser for every asynchronous status pin of the bank.
// Assumes all raw pins come from outside the sys_clk domain.
`timescale 1ns/1ps
`include "sscb_consts.svh"

module sscb_sync (
  input wire logic    sys_clk,  // System clock.
  input wire logic    sys_rst,  // Asynchronous reset, active high.
  sscb_pin_if.sync_side pins    // Raw pins in, synchronised copies out.
);
  logic [`SSCB_SYNC_W-1:0] stage1_reg;
  logic [`SSCB_SYNC_W-1:0] stage2_reg;

  // The first stage feeds only the second; nothing else looks at it.
  genvar i;
  generate
    for (i = 0; i < `SSCB_SYNC_W; i = i + 1) begin : g_bit
      always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
          stage1_reg[i] <= 1'b0;
          stage2_reg[i] <= 1'b0;
        end else begin
          stage1_reg[i] <= pins.raw[i];
          stage2_reg[i] <= stage1_reg[i];
        end
      end
    end
  endgenerate

  assign pins.sync = stage2_reg;
endmodule
